//--- design/optic_ctl_pkg.sv
// constants, state encodings and timing counts of the pluggable optic
// control block; shared by the top module, its id link and the interface
package optic_ctl_pkg;

	// system clock and supervisory hold time
	localparam longint unsigned CLOCK_HZ       = 64'd200_000_000;
	localparam longint unsigned RESET_HOLD_MS  = 64'd140;
	localparam longint unsigned MS_PER_S       = 64'd1000;
	// least time rounds up to whole cycles
	localparam int RESET_HOLD_CYCLES = int'((RESET_HOLD_MS * CLOCK_HZ
		+ MS_PER_S - 64'd1) / MS_PER_S);

	localparam int SYNC_STAGES = 2;

	// identification memory and two-wire slave address
	localparam int        ID_ADDR_W      = 8;
	localparam int        ID_DATA_W      = 8;
	localparam int        ID_MEM_DEPTH   = 256;
	localparam logic [6:0] ID_DEVICE_ADDR = 7'h50;
	localparam logic [7:0] ID_BYTE_RESET  = 8'h00;

	// pin input vector positions in the synchroniser
	localparam int IN_TX_OFF   = 0;
	localparam int IN_FAULT    = 1;
	localparam int IN_SUPPLY   = 2;
	localparam int IN_RX_LOW   = 3;
	localparam int IN_LINK_BSY = 4;
	localparam int IN_COUNT    = 5;
	// a released transmitter-off pin reads high: the safe reset value
	localparam logic [IN_COUNT-1:0] IN_RESET = 5'h05;

	typedef enum logic [0:0] {
		SUP_HOLD = 1'b0,
		SUP_RUN  = 1'b1
	} sup_state_t;

	typedef enum logic [2:0] {
		ID_IDLE     = 3'b000,
		ID_ADDR     = 3'b001,
		ID_ACK_ADDR = 3'b010,
		ID_WORD     = 3'b011,
		ID_ACK_WORD = 3'b100,
		ID_WAIT     = 3'b101,
		ID_READ     = 3'b110,
		ID_READ_ACK = 3'b111
	} id_state_t;

endpackage : optic_ctl_pkg

//--- design/id_mem_if.sv
// read path of the identification memory between the link-side slave and
// the memory held by the top module; address and data are link-clock words
`timescale 1ns/1ps
`default_nettype none
interface id_mem_if;
	logic [optic_ctl_pkg::ID_ADDR_W-1:0] rd_addr;
	logic [optic_ctl_pkg::ID_DATA_W-1:0] rd_data;
	logic                                frame_active;

	modport memory (input rd_addr, output rd_data, input frame_active);
	modport reader (output rd_addr, input rd_data, output frame_active);
endinterface : id_mem_if
`default_nettype wire

//--- design/id_serial_slave.sv
// two-wire identification slave, read-only, clocked by the host's serial
// clock; assumes the host changes data only while the clock is low
`timescale 1ns/1ps
`default_nettype none
module id_serial_slave (
	input  wire logic id_serial_clock,
	input  wire logic reset,
	input  wire logic id_serial_data_in,
	output logic      id_serial_data_out,
	output logic      id_serial_data_oe,
	id_mem_if.reader  mem
);
	logic [1:0]               rst_sync_ff;
	logic                     link_reset;
	logic                     sda_rise_ff;
	optic_ctl_pkg::id_state_t state_ff;
	optic_ctl_pkg::id_state_t nxt_state;
	logic [2:0]               cnt_ff;
	logic [2:0]               nxt_cnt;
	logic [7:0]               shift_ff;
	logic [7:0]               nxt_shift;
	logic [7:0]               ptr_ff;
	logic [7:0]               nxt_ptr;
	logic                     oe_ff;
	logic                     nxt_oe;
	logic                     start_seen;
	logic [7:0]               rx_byte;
	logic                     busy_ff;
	logic                     nxt_busy;

	// reset asserts at once, releases on the link clock; the clock may
	// stand still, so the slave simply stays reset until the host clocks
	always_ff @(posedge id_serial_clock or posedge reset) begin
		if (reset) begin
			rst_sync_ff <= 2'h3;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b0};
		end
	end
	assign link_reset = rst_sync_ff[1];

	// data bit as seen while the clock is high
	always_ff @(posedge id_serial_clock or posedge link_reset) begin
		if (link_reset) begin
			sda_rise_ff <= 1'b1;
		end else begin
			sda_rise_ff <= id_serial_data_in;
		end
	end

	// a start is data falling while the clock is high; a stop followed by
	// a start shows no clock edge, so a low bit while idle counts as one
	assign start_seen = (sda_rise_ff && !id_serial_data_in)
		|| ((state_ff == optic_ctl_pkg::ID_IDLE
		|| state_ff == optic_ctl_pkg::ID_WAIT) && !id_serial_data_in);
	assign rx_byte = {shift_ff[6:0], sda_rise_ff};

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_shift = shift_ff;
		nxt_ptr   = ptr_ff;
		nxt_oe    = 1'b0;
		if (start_seen) begin
			nxt_state = optic_ctl_pkg::ID_ADDR;
			nxt_cnt   = 3'h0;
		end else begin
			unique case (state_ff)
			optic_ctl_pkg::ID_IDLE, optic_ctl_pkg::ID_WAIT: begin
				nxt_state = state_ff;
			end
			optic_ctl_pkg::ID_ADDR, optic_ctl_pkg::ID_WORD: begin
				nxt_shift = rx_byte;
				nxt_cnt   = cnt_ff + 3'h1;
				if (cnt_ff == 3'h7) begin
					if (state_ff == optic_ctl_pkg::ID_WORD) begin
						nxt_ptr   = rx_byte;
						nxt_oe    = 1'b1;
						nxt_state = optic_ctl_pkg::ID_ACK_WORD;
					end else if (rx_byte[7:1]
						== optic_ctl_pkg::ID_DEVICE_ADDR) begin
						nxt_oe    = 1'b1;
						nxt_state = optic_ctl_pkg::ID_ACK_ADDR;
					end else begin
						nxt_state = optic_ctl_pkg::ID_IDLE;
					end
				end
			end
			optic_ctl_pkg::ID_ACK_ADDR: begin
				nxt_cnt = 3'h0;
				if (shift_ff[0]) begin
					nxt_shift = mem.rd_data;
					nxt_oe    = !mem.rd_data[7];
					nxt_state = optic_ctl_pkg::ID_READ;
				end else begin
					nxt_state = optic_ctl_pkg::ID_WORD;
				end
			end
			// writes beyond the word address are not supported
			optic_ctl_pkg::ID_ACK_WORD: begin
				nxt_state = optic_ctl_pkg::ID_WAIT;
			end
			optic_ctl_pkg::ID_READ: begin
				nxt_cnt = cnt_ff + 3'h1;
				if (cnt_ff == 3'h7) begin
					nxt_ptr   = ptr_ff + 8'h01;
					nxt_state = optic_ctl_pkg::ID_READ_ACK;
				end else begin
					nxt_shift = {shift_ff[6:0], 1'b0};
					nxt_oe    = !shift_ff[6];
				end
			end
			optic_ctl_pkg::ID_READ_ACK: begin
				nxt_cnt = 3'h0;
				if (!sda_rise_ff) begin
					nxt_shift = mem.rd_data;
					nxt_oe    = !mem.rd_data[7];
					nxt_state = optic_ctl_pkg::ID_READ;
				end else begin
					nxt_state = optic_ctl_pkg::ID_IDLE;
				end
			end
			endcase
		end
		nxt_busy = (nxt_state != optic_ctl_pkg::ID_IDLE);
	end

	// state moves and the data pin changes only while the clock is low
	always_ff @(negedge id_serial_clock or posedge link_reset) begin
		if (link_reset) begin
			state_ff <= optic_ctl_pkg::ID_IDLE;
			cnt_ff   <= 3'h0;
			shift_ff <= optic_ctl_pkg::ID_BYTE_RESET;
			ptr_ff   <= optic_ctl_pkg::ID_BYTE_RESET;
			oe_ff    <= 1'b0;
			busy_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			shift_ff <= nxt_shift;
			ptr_ff   <= nxt_ptr;
			oe_ff    <= nxt_oe;
			busy_ff  <= nxt_busy;
		end
	end

	assign id_serial_data_out = 1'b0;
	assign id_serial_data_oe  = oe_ff;
	assign mem.rd_addr        = ptr_ff;
	// registered: a decode of several state bits could glitch into the
	// system-side synchroniser
	assign mem.frame_active   = busy_ff;

endmodule : id_serial_slave
`default_nettype wire

//--- design/optic_control.sv
// control and status logic of a pluggable optical transceiver: laser
// fault latch and shutdown, transmitter off, signal-lost flag, presence
// line, supply supervisor and the identification memory with its link.
// assumes the status pins arrive asynchronously and that the host drives
// the serial clock; the supervisor comparator is outside this block.
//
// Functional notes
// - laser fault drives the fault flag high and switches the laser off
// - transmitter on only while the off request is low; high keeps it off
// - presence line is held at ground so the host sees a module
// - signal-lost flag low with light present, high below sensitivity
// - internal reset asserts whenever supply is below the threshold
// - reset stays asserted at least 140 ms after the supply recovers
// - laser stays off for the whole supervisory reset
// - automatic shutdown disables the laser as soon as a fault is seen
// - serial data line is the two-way data wire of the id link
// - identification reads are answered from the internal memory
`timescale 1ns/1ps
`default_nettype none
module optic_control #(
	parameter int RESET_HOLD_CYCLES = optic_ctl_pkg::RESET_HOLD_CYCLES,
	parameter int ID_MEM_DEPTH      = optic_ctl_pkg::ID_MEM_DEPTH
) (
	input  wire logic                                clock,
	input  wire logic                                reset,
	input  wire logic                                transmitter_off_input,
	input  wire logic                                laser_fault_detect,
	input  wire logic                                supply_below_threshold,
	input  wire logic                                rx_power_below_sens,
	output logic                                     laser_fault_flag,
	output logic                                     laser_enable,
	output logic                                     supervisory_reset,
	output logic                                     optical_signal_lost,
	output logic                                     module_present_line_out,
	output logic                                     module_present_line_oe,
	output logic                                     id_link_busy,
	input  wire logic                                id_mem_write,
	input  wire logic [optic_ctl_pkg::ID_ADDR_W-1:0] id_mem_write_addr,
	input  wire logic [optic_ctl_pkg::ID_DATA_W-1:0] id_mem_write_data,
	input  wire logic                                id_serial_clock,
	input  wire logic                                id_serial_data_in,
	output logic                                     id_serial_data_out,
	output logic                                     id_serial_data_oe
);
	localparam int HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST =
		HOLD_W'(RESET_HOLD_CYCLES - 1);

	logic [optic_ctl_pkg::IN_COUNT-1:0] meta_ff;
	logic [optic_ctl_pkg::IN_COUNT-1:0] sync_ff;
	logic [optic_ctl_pkg::IN_COUNT-1:0] pins_async;
	logic                               tx_off_s;
	logic                               fault_s;
	logic                               supply_low_s;
	logic                               rx_low_s;

	optic_ctl_pkg::sup_state_t          sup_state_ff;
	optic_ctl_pkg::sup_state_t          nxt_sup_state;
	logic [HOLD_W-1:0]                  hold_cnt_ff;
	logic [HOLD_W-1:0]                  nxt_hold_cnt;

	logic                               fault_ff;
	logic                               nxt_fault;
	logic                               laser_on_ff;
	logic                               nxt_laser_on;
	logic                               los_ff;
	logic                               nxt_los;

	logic [optic_ctl_pkg::ID_DATA_W-1:0] id_mem [ID_MEM_DEPTH];

	id_mem_if mem_bus ();

	// gathered at their named positions so the order cannot drift
	assign pins_async[optic_ctl_pkg::IN_TX_OFF]   = transmitter_off_input;
	assign pins_async[optic_ctl_pkg::IN_FAULT]    = laser_fault_detect;
	assign pins_async[optic_ctl_pkg::IN_SUPPLY]   = supply_below_threshold;
	assign pins_async[optic_ctl_pkg::IN_RX_LOW]   = rx_power_below_sens;
	assign pins_async[optic_ctl_pkg::IN_LINK_BSY] = mem_bus.frame_active;

	// every pin input and the link busy level pass two flip-flops; the
	// bits are independent levels, so no word coherence is needed
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_ff <= optic_ctl_pkg::IN_RESET;
			sync_ff <= optic_ctl_pkg::IN_RESET;
		end else begin
			meta_ff <= pins_async;
			sync_ff <= meta_ff;
		end
	end
	assign tx_off_s     = sync_ff[optic_ctl_pkg::IN_TX_OFF];
	assign fault_s      = sync_ff[optic_ctl_pkg::IN_FAULT];
	assign supply_low_s = sync_ff[optic_ctl_pkg::IN_SUPPLY];
	assign rx_low_s     = sync_ff[optic_ctl_pkg::IN_RX_LOW];

	// supply supervisor: hold starts at power-up and on every dip
	always_comb begin
		nxt_sup_state = sup_state_ff;
		nxt_hold_cnt  = hold_cnt_ff;
		if (supply_low_s) begin
			nxt_sup_state = optic_ctl_pkg::SUP_HOLD;
			nxt_hold_cnt  = '0;
		end else begin
			unique case (sup_state_ff)
			optic_ctl_pkg::SUP_HOLD: begin
				if (hold_cnt_ff == HOLD_LAST) begin
					nxt_sup_state = optic_ctl_pkg::SUP_RUN;
				end else begin
					nxt_hold_cnt = hold_cnt_ff + HOLD_W'(1);
				end
			end
			optic_ctl_pkg::SUP_RUN: begin
				nxt_hold_cnt = '0;
			end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sup_state_ff <= optic_ctl_pkg::SUP_HOLD;
			hold_cnt_ff  <= '0;
		end else begin
			sup_state_ff <= nxt_sup_state;
			hold_cnt_ff  <= nxt_hold_cnt;
		end
	end

	// fault stays latched until the host requests transmitter off while
	// the fault has gone; a fault in that same cycle keeps it set
	always_comb begin
		nxt_fault = fault_ff;
		if (tx_off_s && !fault_s) begin
			nxt_fault = 1'b0;
		end
		if (fault_s) begin
			nxt_fault = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fault_ff <= 1'b0;
		end else begin
			fault_ff <= nxt_fault;
		end
	end

	// raw synchronised fault also gates, so shutdown needs no latch; the
	// supervisor's next state is used so the laser never outlives a hold
	always_comb begin
		nxt_laser_on = !tx_off_s
			&& !fault_s && !fault_ff
			&& !supply_low_s
			&& nxt_sup_state == optic_ctl_pkg::SUP_RUN;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			laser_on_ff <= 1'b0;
		end else begin
			laser_on_ff <= nxt_laser_on;
		end
	end

	// no light is the safe state of the flag while in reset
	always_comb begin
		nxt_los = rx_low_s;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			los_ff <= 1'b1;
		end else begin
			los_ff <= nxt_los;
		end
	end

	// identification memory: written on the system clock, read by the
	// link with no synchroniser; content changed mid-read may tear a byte
	always_ff @(posedge clock) begin
		if (id_mem_write) begin
			id_mem[id_mem_write_addr] <= id_mem_write_data;
		end
	end
	assign mem_bus.rd_data = id_mem[mem_bus.rd_addr];

	// the slave is clocked only by the host's serial clock
	id_serial_slave u_id_slave (
		.id_serial_clock    (id_serial_clock),
		.reset              (reset),
		.id_serial_data_in  (id_serial_data_in),
		.id_serial_data_out (id_serial_data_out),
		.id_serial_data_oe  (id_serial_data_oe),
		.mem                (mem_bus.reader)
	);

	assign laser_fault_flag        = fault_ff;
	assign laser_enable            = laser_on_ff;
	assign supervisory_reset       = (sup_state_ff == optic_ctl_pkg::SUP_HOLD);
	assign optical_signal_lost     = los_ff;
	assign id_link_busy            = sync_ff[optic_ctl_pkg::IN_LINK_BSY];
	// presence line is a permanent ground, not a logic level
	assign module_present_line_out = 1'b0;
	assign module_present_line_oe  = 1'b1;

endmodule : optic_control
`default_nettype wire

//--- tb/optic_control_props.sv
// concurrent checks on the optic control top ports
// assumes the bench moves pins away from the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module optic_control_props #(
	parameter int RESET_HOLD_CYCLES = 64
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic transmitter_off_input,
	input wire logic laser_fault_detect,
	input wire logic supply_below_threshold,
	input wire logic rx_power_below_sens,
	input wire logic laser_fault_flag,
	input wire logic laser_enable,
	input wire logic supervisory_reset,
	input wire logic optical_signal_lost,
	input wire logic module_present_line_out,
	input wire logic module_present_line_oe,
	input wire logic id_serial_clock,
	input wire logic id_serial_data_oe
);
	// cycles the supply pin has been good; no saturation, runs are short
	logic [31:0] low_ff;
	logic [31:0] nxt_low;
	always_comb begin
		nxt_low = supply_below_threshold ? 32'h0 : low_ff + 32'h1;
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			low_ff <= 32'h0;
		else
			low_ff <= nxt_low;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	fault_sets_flag_a: assert property (laser_fault_detect [*5] |=>
		laser_fault_flag && !laser_enable) else $error("fault not flagged");
	tx_off_disables_a: assert property (transmitter_off_input [*5] |=>
		!laser_enable) else $error("laser on with off request");
	presence_grounded_a: assert property (module_present_line_oe &&
		!module_present_line_out) else $error("presence not grounded");
	lost_sets_a: assert property (rx_power_below_sens [*5] |=>
		optical_signal_lost) else $error("signal lost not raised");
	lost_clears_a: assert property (!rx_power_below_sens [*5] |=>
		!optical_signal_lost) else $error("signal lost not cleared");
	supply_resets_a: assert property (supply_below_threshold [*5] |=>
		supervisory_reset) else $error("no reset on low supply");
	hold_min_a: assert property ($fell(supervisory_reset) |->
		low_ff >= 32'(RESET_HOLD_CYCLES)) else $error("reset released early");
	hold_max_a: assert property (low_ff == 32'(RESET_HOLD_CYCLES + 8) |->
		!supervisory_reset) else $error("reset never released");
	laser_off_reset_a: assert property (supervisory_reset |->
		!laser_enable) else $error("laser on during reset");
	enable_clean_a: assert property ($rose(laser_enable) |->
		!laser_fault_flag && !supervisory_reset) else $error("bad enable");
	data_steady_a: assert property (id_serial_clock &&
		$past(id_serial_clock) |-> $stable(id_serial_data_oe))
		else $error("data moved while clock high");
endmodule : optic_control_props

bind optic_control optic_control_props #(
	.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)
) i_props (
	.clock(clock), .reset(reset),
	.transmitter_off_input(transmitter_off_input),
	.laser_fault_detect(laser_fault_detect),
	.supply_below_threshold(supply_below_threshold),
	.rx_power_below_sens(rx_power_below_sens),
	.laser_fault_flag(laser_fault_flag), .laser_enable(laser_enable),
	.supervisory_reset(supervisory_reset),
	.optical_signal_lost(optical_signal_lost),
	.module_present_line_out(module_present_line_out),
	.module_present_line_oe(module_present_line_oe),
	.id_serial_clock(id_serial_clock), .id_serial_data_oe(id_serial_data_oe)
);
`default_nettype wire

//--- tb/id_host_model.sv
// host controller model on the id link: makes the serial clock in frames
// and in idle runs, and pulls the data wire low; assumes a pull-up in the bench
`timescale 1ns/1ps
`default_nettype none
module id_host_model (
	output logic       id_serial_clock,
	output logic       pull_low,
	input  wire logic  sda,
	output logic [8:0] result,
	output logic       result_tgl
);
	// a quarter of the 125 ns serial period
	localparam realtime Q = 31.25;
	initial begin
		id_serial_clock = 1'b1;
		pull_low = 1'b0;
		result = 9'h000;
		result_tgl = 1'b0;
	end
	task automatic post(input logic [8:0] r);
		result = r;
		result_tgl = !result_tgl;
	endtask : post
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		#(Q) pull_low = !b;
		#(Q) id_serial_clock = 1'b1;
		#(Q) s = sda;
		#(Q) id_serial_clock = 1'b0;
	endtask : bit_io
	task automatic idle(input int n);
		repeat (n) begin
			#(2 * Q) id_serial_clock = 1'b0;
			#(2 * Q) id_serial_clock = 1'b1;
		end
	endtask : idle
	task automatic start();
		if (!id_serial_clock) begin
			#(Q) pull_low = 1'b0;
			#(Q) id_serial_clock = 1'b1;
		end
		#(Q) pull_low = 1'b1;
		#(Q) id_serial_clock = 1'b0;
	endtask : start
	task automatic stop();
		#(Q) pull_low = 1'b1;
		#(Q) id_serial_clock = 1'b1;
		#(Q) pull_low = 1'b0;
		#(Q);
	endtask : stop
	task automatic send(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, s);
		post({1'b1, 7'h00, s});
	endtask : send
	task automatic recv(input logic last);
		logic [7:0] v;
		logic       s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			v[i] = s;
		end
		bit_io(last, s);
		post({1'b0, v});
	endtask : recv
endmodule : id_host_model
`default_nettype wire

//--- tb/optic_control_tb.sv
// self-checking bench of the optic control block with a host model
// assumes each id-link byte is announced by a toggle of the model
`timescale 1ns/1ps
`default_nettype none
module optic_control_tb;
	localparam int HOLD = 64;
	logic        clock, reset, tx_off, fault, supply, rx_low, mem_wr;
	logic [7:0]  wr_addr, wr_data;
	logic [7:0]  exp_mem [256];
	logic        scl, host_low, oe, out, busy, lost, flag, laser, sup;
	logic        p_out, p_oe, res_tgl;
	logic [8:0]  res;
	logic [8:0]  exp_q [$];
	logic [31:0] seed;
	int          failures, num_checks;
	wire logic   sda;
	assign sda = !(host_low || oe);

	optic_control #(.RESET_HOLD_CYCLES(HOLD)) i_dut (
		.clock(clock), .reset(reset), .transmitter_off_input(tx_off),
		.laser_fault_detect(fault), .supply_below_threshold(supply),
		.rx_power_below_sens(rx_low), .laser_fault_flag(flag),
		.laser_enable(laser), .supervisory_reset(sup),
		.optical_signal_lost(lost), .module_present_line_out(p_out),
		.module_present_line_oe(p_oe), .id_link_busy(busy),
		.id_mem_write(mem_wr), .id_mem_write_addr(wr_addr),
		.id_mem_write_data(wr_data), .id_serial_clock(scl),
		.id_serial_data_in(sda), .id_serial_data_out(out),
		.id_serial_data_oe(oe)
	);
	id_host_model i_host (.id_serial_clock(scl), .pull_low(host_low),
		.sda(sda), .result(res), .result_tgl(res_tgl));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic check_res(input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : check_res
	task automatic check_pin(input logic e, input logic g);
		check_res({8'h00, e}, {8'h00, g});
	endtask : check_pin
	task automatic cycles(input int n);
		repeat (n) @(negedge clock);
	endtask : cycles
	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// counts cycles until the supervisor lets go, bounded
	task automatic wait_sup(output int n);
		n = 0;
		while (sup !== 1'b0 && n < 4 * HOLD) begin
			@(negedge clock);
			n++;
		end
		if (n >= 4 * HOLD) begin
			failures++;
			report_and_stop;
		end
	endtask : wait_sup

	initial begin
		#1;
		forever begin
			@(res_tgl);
			if (exp_q.size() == 0) begin
				num_checks++;
				failures++;
				$display("[FAIL] %0t unexpected id result %h", $time, res);
			end else
				check_res(exp_q.pop_front(), res);
		end
	end

	initial begin
		int   n;
		logic exp_flag;
		reset = 1'b1;
		tx_off = 1'b1;
		fault = 1'b0;
		supply = 1'b0;
		rx_low = 1'b0;
		mem_wr = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		exp_flag = 1'b0;
		seed = 32'h651C0DA1;
		failures = 0;
		num_checks = 0;
		cycles(16);
		reset = 1'b0;
		tx_off = 1'b0;
		check_pin(1'b1, p_oe);
		check_pin(1'b0, p_out);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			mem_wr = 1'b1;
			wr_addr = 8'hFD + 8'(i);
			wr_data = seed[7:0];
			exp_mem[wr_addr] = seed[7:0];
			@(negedge clock);
		end
		mem_wr = 1'b0;
		cycles(HOLD / 2);
		check_pin(1'b0, laser);
		wait_sup(n);
		cycles(3);
		check_pin(1'b1, laser);
		supply = 1'b1;
		cycles(5);
		check_pin(1'b1, sup);
		check_pin(1'b0, laser);
		supply = 1'b0;
		wait_sup(n);
		check_pin(1'b1, n >= HOLD && n <= HOLD + 6);
		cycles(3);
		check_pin(1'b1, laser);
		fault = 1'b1;
		cycles(5);
		check_pin(1'b1, flag);
		check_pin(1'b0, laser);
		fault = 1'b0;
		cycles(5);
		check_pin(1'b1, flag);
		tx_off = 1'b1;
		cycles(5);
		check_pin(1'b0, flag);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			tx_off = seed[0];
			rx_low = seed[1];
			fault = seed[2] & seed[3];
			if (fault)
				exp_flag = 1'b1;
			else if (tx_off)
				exp_flag = 1'b0;
			cycles(5);
			check_pin(!tx_off && !exp_flag, laser);
			check_pin(exp_flag, flag);
			check_pin(rx_low, lost);
		end
		fault = 1'b0;
		tx_off = 1'b0;
		cycles(5);
		i_host.idle(3);
		for (int i = 0; i < 3; i++) exp_q.push_back(9'h100);
		for (int i = 0; i < 4; i++)
			exp_q.push_back({1'b0, exp_mem[8'hFE + 8'(i)]});
		i_host.start();
		i_host.send(8'hA0);
		check_pin(1'b1, busy);
		i_host.send(8'hFE);
		i_host.start();
		i_host.send(8'hA1);
		for (int i = 0; i < 4; i++) i_host.recv(i == 3);
		i_host.stop();
		exp_q.push_back(9'h100);
		exp_q.push_back({1'b0, exp_mem[8'h02]});
		i_host.start();
		i_host.send(8'hA1);
		i_host.recv(1'b1);
		i_host.stop();
		exp_q.push_back(9'h101);
		i_host.start();
		i_host.send(8'hA2);
		i_host.stop();
		cycles(10);
		check_pin(1'b0, busy);
		check_pin(1'b1, exp_q.size() == 0);
		report_and_stop;
	end
endmodule : optic_control_tb
`default_nettype wire
